// >>> dv/dls_checker.sv
`timescale 1ns/1ns
`include "dls_regs.vh"
// ====================
// Port checker
module dls_checker (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Register port
    input wire [11:0] reg_addr,
    input wire reg_rd,
    input wire reg_wr,
    input wire [31:0] reg_wdata,
    input wire [31:0] reg_rdata,
    // Scan side
    input wire [31:0] periodic_valid,
    input wire periodic_exec_ready,
    input wire periodic_exec_valid,
    input wire [4:0] periodic_exec_slot,
    input wire async_exec_ready,
    input wire async_exec_valid,
    input wire [4:0] async_exec_slot,
    input wire periodic_done_valid,
    input wire [4:0] periodic_done_slot
);
    reg [31:0] skip_reg;
    reg [31:0] last_reg;
    wire rdp = reg_rd && reg_addr == `DLS_PERIODIC_DONE_OFS;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Shadow maps so offers can be judged without seeing the bodies
    always @(posedge clock) begin
        if (rst) begin
            skip_reg <= `DLS_SKIP_RST;
            last_reg <= `DLS_LAST_RST;
        end else if (reg_wr && reg_addr == `DLS_PERIODIC_SKIP_OFS)
            skip_reg <= reg_wdata;
        else if (reg_wr && reg_addr == `DLS_PERIODIC_LAST_OFS)
            last_reg <= reg_wdata;
    end
    AST_P_HOLD: assert property (periodic_exec_valid && !periodic_exec_ready
        |=> periodic_exec_valid && $stable(periodic_exec_slot))
        else $error("periodic offer dropped");
    AST_A_HOLD: assert property (async_exec_valid && !async_exec_ready
        |=> async_exec_valid && $stable(async_exec_slot))
        else $error("async offer dropped");
    AST_SKIP: assert property (periodic_exec_valid
        |-> !skip_reg[periodic_exec_slot]) else $error("skipped slot offered");
    AST_VALID: assert property (periodic_exec_valid
        |-> periodic_valid[periodic_exec_slot]) else $error("invalid offered");
    AST_LAST: assert property (periodic_exec_valid && last_reg != 0
        |-> (last_reg >> periodic_exec_slot) != 0) else $error("past last");
    AST_DONE_SET: assert property (rdp && $past(periodic_done_valid)
        |=> reg_rdata[$past(periodic_done_slot, 2)]) else $error("done lost");
    AST_CLEAR: assert property (rdp && !periodic_done_valid ##1
        rdp && !periodic_done_valid |=> reg_rdata == 32'h0)
        else $error("done not cleared");
    AST_SKIP_RB: assert property (reg_wr && reg_addr == 12'h144
        ##1 reg_rd && reg_addr == 12'h144 |=> reg_rdata == $past(reg_wdata, 2))
        else $error("skip readback");
    AST_UNMAP: assert property (reg_rd && reg_addr == 12'h15c
        |=> reg_rdata == 32'h0) else $error("unmapped read");
endmodule // dls_checker
bind dls_top dls_checker u_chk (.*);

// >>> dv/dls_exec_model.sv
`timescale 1ns/1ns
// ====================
// Execution engine: takes offers, reports completion a cycle later
module dls_exec_model (
    // Clock and stall
    input wire clock,
    input wire stall,
    // Offer
    input wire exec_valid,
    input wire [4:0] exec_slot,
    output reg exec_ready = 1'b0,
    // Completion
    output reg done_valid = 1'b0,
    output reg [4:0] done_slot = 5'h00
);
    reg acc_reg = 1'b0;
    reg [4:0] slot_reg = 5'h00;
    // Capture the accepted slot at the sampling edge
    always @(posedge clock) begin
        acc_reg <= exec_valid && exec_ready;
        slot_reg <= exec_slot;
    end
    // Idle slot lines toggle so a stale index is never trusted
    always @(negedge clock) begin
        exec_ready <= !stall;
        done_valid <= acc_reg;
        done_slot <= acc_reg ? slot_reg : ~done_slot;
    end
endmodule // dls_exec_model

// >>> dv/dls_top_tb.sv
`timescale 1ns/1ns
module dls_top_tb;
    reg clock = 1'b0;
    reg rst = 1'b1;
    reg [11:0] reg_addr = 12'h000;
    reg reg_rd = 1'b0;
    reg reg_wr = 1'b0;
    reg [31:0] reg_wdata = 32'h0;
    reg [31:0] periodic_valid = 32'h0;
    reg [31:0] async_valid = 32'h0;
    reg scan_en = 1'b0;
    reg p_stall = 1'b1;
    wire [31:0] reg_rdata;
    wire periodic_exec_ready, periodic_exec_valid, periodic_done_valid;
    wire async_exec_ready, async_exec_valid, async_done_valid;
    wire [4:0] periodic_exec_slot, periodic_done_slot;
    wire [4:0] async_exec_slot, async_done_slot;
    logic [31:0] rd_data;
    logic [31:0] acc_done = 32'h0;
    logic [4:0] pq[$];
    logic [4:0] aq[$];
    int miscompares = 0;
    int samples_checked = 0;
    logic [11:0] ofs[7] = '{12'h140, 12'h144, 12'h148, 12'h150, 12'h154,
        12'h158, 12'h15c};
    logic [31:0] rv[7] = '{32'h0, 32'hffffffff, 32'h0, 32'h0, 32'hffffffff,
        32'h0, 32'h0};
    always #50 clock = ~clock;
    dls_top u_dut (.*);
    dls_exec_model u_pm (.clock(clock), .stall(p_stall),
        .exec_valid(periodic_exec_valid), .exec_slot(periodic_exec_slot),
        .exec_ready(periodic_exec_ready), .done_valid(periodic_done_valid),
        .done_slot(periodic_done_slot));
    dls_exec_model u_am (.clock(clock), .stall(1'b0),
        .exec_valid(async_exec_valid), .exec_slot(async_exec_slot),
        .exec_ready(async_exec_ready), .done_valid(async_done_valid),
        .done_slot(async_done_slot));
    // Log every accepted offer in order
    always @(posedge clock) begin
        if (periodic_exec_valid && periodic_exec_ready)
            pq.push_back(periodic_exec_slot);
        if (async_exec_valid && async_exec_ready)
            aq.push_back(async_exec_slot);
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    // Both tasks start and end at a falling edge; a write leaves its strobe
    // up so back-to-back calls never assign one signal twice in a step
    task wr(input logic [11:0] a, input logic [31:0] d);
        reg_rd = 1'b0;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clock);
    endtask
    task rd(input logic [11:0] a);
        reg_wr = 1'b0;
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        @(negedge clock);
        rd_data = reg_rdata;
    endtask
    task report_and_stop;
        if (miscompares == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #200000;
        miscompares++;
        report_and_stop;
    end
    initial begin
        repeat (8) @(negedge clock);
        rst = 1'b0;
        for (int i = 0; i < 7; i++) begin
            rd(ofs[i]);
            chk("reset value", rv[i], rd_data);
        end
        wr(12'h140, 32'hffffffff);
        rd(12'h140);
        chk("done read-only", 32'h0, rd_data);
        wr(12'h144, 32'h2);
        rd(12'h144);
        chk("periodic skip", 32'h2, rd_data);
        wr(12'h148, 32'h4);
        wr(12'h154, 32'h0);
        wr(12'h158, 32'h2);
        rd(12'h158);
        chk("async last", 32'h2, rd_data);
        // Periodic side stalls first so the offer must hold
        periodic_valid = 32'h7;
        async_valid = 32'hff;
        scan_en = 1'b1;
        repeat (6) @(negedge clock);
        p_stall = 1'b0;
        // Reads while completions arrive; no completion may be lost
        repeat (12) begin
            rd(12'h140);
            acc_done = acc_done | rd_data;
        end
        scan_en = 1'b0;
        repeat (6) @(negedge clock);
        chk("periodic runs", 32'h1, 32'(pq.size() > 3));
        for (int i = 0; i < pq.size(); i++)
            chk("periodic slot", (i % 2) ? 2 : 0, pq[i]);
        chk("async runs", 32'h1, 32'(aq.size() > 3));
        for (int i = 0; i < aq.size(); i++)
            chk("async slot", i % 2, aq[i]);
        rd(12'h140);
        chk("periodic done", 32'h5, acc_done | rd_data);
        // Back-to-back reads: the second sees the cleared map
        reg_rd = 1'b1;
        repeat (2) @(negedge clock);
        reg_rd = 1'b0;
        @(negedge clock);
        chk("periodic cleared", 32'h0, reg_rdata);
        rd(12'h150);
        chk("async done", 32'h3, rd_data);
        rd(12'h150);
        chk("async cleared", 32'h0, rd_data);
        report_and_stop;
    end
endmodule // dls_top_tb

// >>> hdl/dls_done_map.v
`timescale 1ns/1ns
`include "dls_regs.vh"
// Done map with read-to-clear; a completion in the clearing cycle survives
module dls_done_map (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Completion pulse and its slot
    input wire done_valid,
    input wire [4:0] done_slot,
    // Clearing read strobe
    input wire clear_rd,
    // Map contents
    output reg [31:0] map_reg
);
    reg [31:0] set_mask;
    reg [31:0] map_next;

    // Set beats clear so no completion is lost
    always @* begin
        set_mask = 32'h00000000;
        if (done_valid) begin
            set_mask[done_slot] = 1'b1;
        end
        map_next = (clear_rd ? 32'h00000000 : map_reg) | set_mask;
    end

    // Storage
    always @(posedge clock) begin
        if (rst) begin
            map_reg <= `DLS_DONE_RST;
        end else begin
            map_reg <= map_next;
        end
    end
endmodule // dls_done_map

// >>> hdl/dls_regs.vh
`ifndef DLS_REGS_VH
`define DLS_REGS_VH
// Register byte offsets
`define DLS_PERIODIC_DONE_OFS 12'h140
`define DLS_PERIODIC_SKIP_OFS 12'h144
`define DLS_PERIODIC_LAST_OFS 12'h148
`define DLS_ASYNC_DONE_OFS 12'h150
`define DLS_ASYNC_SKIP_OFS 12'h154
`define DLS_ASYNC_LAST_OFS 12'h158
// Reset values
`define DLS_DONE_RST 32'h00000000
`define DLS_SKIP_RST 32'hffffffff
`define DLS_LAST_RST 32'h00000000
// Slot count and index width
`define DLS_SLOTS 32
`define DLS_IDX_W 5
`endif

// >>> hdl/dls_scanner.v
`timescale 1ns/1ns
`include "dls_regs.vh"
// Slot scanner for one category: walks slots 0..last, at most one slot per cycle
module dls_scanner (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Scan control
    input wire scan_en,
    input wire [31:0] valid_map,
    input wire [31:0] skip_map,
    input wire [31:0] last_map,
    // Execution handshake
    input wire exec_ready,
    // Outputs
    output reg exec_valid,
    output reg [4:0] exec_slot,
    output reg [4:0] scan_slot
);
    wire hit;
    wire at_last;

    // A slot runs only with valid set and skip clear
    assign hit = valid_map[scan_slot] & ~skip_map[scan_slot];
    // Any last bit or slot 31 closes the pass
    assign at_last = last_map[scan_slot] | (scan_slot == 5'h1f);

    // Scan pointer only advances sequentially; pointers in skipped
    // descriptors are never consulted
    always @(posedge clock) begin
        if (rst) begin
            scan_slot <= 5'h00;
            exec_valid <= 1'b0;
            exec_slot <= 5'h00;
        end else begin
            if (exec_valid && exec_ready) begin
                exec_valid <= 1'b0;
            end
            if (scan_en && !(exec_valid && !exec_ready)) begin
                if (hit && !(exec_valid && exec_ready)) begin
                    exec_valid <= 1'b1;
                    exec_slot <= scan_slot;
                end
                if (!hit || !(exec_valid && exec_ready)) begin
                    if (at_last) begin
                        scan_slot <= 5'h00;
                    end else begin
                        scan_slot <= scan_slot + 5'h01;
                    end
                end
            end
        end
    end
endmodule // dls_scanner

// >>> hdl/dls_top.v
// Operation
// - Each done map holds 32 bits, bit n reports descriptor slot n.
// - A slot's done bit sets when its descriptor completes.
// - Reading a done map returns it and clears the set bits.
// - Done maps at 0x140 and 0x150, read-only, reset to zero.
// - Skip maps at 0x144 and 0x154, writable, reset to all ones.
// - A skipped descriptor is never processed, even if valid.
// - Next pointers in skipped descriptors do not change scan order.
// - Last maps at 0x148 and 0x158, writable, reset to zero.
// - The slot with its last bit set ends the pass.
// - After the last slot, scanning restarts at slot zero.
// - Last map is one bit per slot: 1h one, 2h two, 4h three.
`timescale 1ns/1ns
`include "dls_regs.vh"
module dls_top (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Register port
    input wire [11:0] reg_addr,
    input wire reg_rd,
    input wire reg_wr,
    input wire [31:0] reg_wdata,
    output reg [31:0] reg_rdata,
    // Per-slot valid flags from descriptor memory
    input wire [31:0] periodic_valid,
    input wire [31:0] async_valid,
    input wire scan_en,
    // Execution handshakes
    input wire periodic_exec_ready,
    input wire async_exec_ready,
    output wire periodic_exec_valid,
    output wire [4:0] periodic_exec_slot,
    output wire async_exec_valid,
    output wire [4:0] async_exec_slot,
    // Completion reports
    input wire periodic_done_valid,
    input wire [4:0] periodic_done_slot,
    input wire async_done_valid,
    input wire [4:0] async_done_slot
);
    // ========================================
    // Register storage
    // ========================================
    reg [31:0] periodic_skip_map_reg;
    reg [31:0] periodic_last_map_reg;
    reg [31:0] async_skip_map_reg;
    reg [31:0] async_last_map_reg;
    wire [31:0] periodic_done_map;
    wire [31:0] async_done_map;
    wire periodic_clr;
    wire async_clr;

    // Reads of a done map clear it in the same cycle the data is latched
    assign periodic_clr = reg_rd && (reg_addr == `DLS_PERIODIC_DONE_OFS);
    assign async_clr = reg_rd && (reg_addr == `DLS_ASYNC_DONE_OFS);

    // Done maps, one bit per slot
    dls_done_map u_periodic_done (
        .clock(clock),
        .rst(rst),
        .done_valid(periodic_done_valid),
        .done_slot(periodic_done_slot),
        .clear_rd(periodic_clr),
        .map_reg(periodic_done_map)
    );
    dls_done_map u_async_done (
        .clock(clock),
        .rst(rst),
        .done_valid(async_done_valid),
        .done_slot(async_done_slot),
        .clear_rd(async_clr),
        .map_reg(async_done_map)
    );

    // ========================================
    // Register writes
    // ========================================
    // Done maps ignore writes; last map is a plain bitmap, not a count
    always @(posedge clock) begin
        if (rst) begin
            periodic_skip_map_reg <= `DLS_SKIP_RST;
            async_skip_map_reg <= `DLS_SKIP_RST;
            periodic_last_map_reg <= `DLS_LAST_RST;
            async_last_map_reg <= `DLS_LAST_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                `DLS_PERIODIC_SKIP_OFS: periodic_skip_map_reg <= reg_wdata;
                `DLS_ASYNC_SKIP_OFS: async_skip_map_reg <= reg_wdata;
                `DLS_PERIODIC_LAST_OFS: begin
                    periodic_last_map_reg <= reg_wdata;
                end
                `DLS_ASYNC_LAST_OFS: async_last_map_reg <= reg_wdata;
                default: begin
                end
            endcase
        end
    end

    // ========================================
    // Register reads
    // ========================================
    // Read data is registered; unmapped offsets read zero
    always @(posedge clock) begin
        if (rst) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                `DLS_PERIODIC_DONE_OFS: reg_rdata <= periodic_done_map;
                `DLS_PERIODIC_SKIP_OFS: reg_rdata <= periodic_skip_map_reg;
                `DLS_PERIODIC_LAST_OFS: reg_rdata <= periodic_last_map_reg;
                `DLS_ASYNC_DONE_OFS: reg_rdata <= async_done_map;
                `DLS_ASYNC_SKIP_OFS: reg_rdata <= async_skip_map_reg;
                `DLS_ASYNC_LAST_OFS: reg_rdata <= async_last_map_reg;
                default: reg_rdata <= 32'h00000000;
            endcase
        end
    end

    // ========================================
    // Scanners, one per category
    // ========================================
    // Separate instances keep the two scans independent
    dls_scanner u_periodic_scan (
        .clock(clock),
        .rst(rst),
        .scan_en(scan_en),
        .valid_map(periodic_valid),
        .skip_map(periodic_skip_map_reg),
        .last_map(periodic_last_map_reg),
        .exec_ready(periodic_exec_ready),
        .exec_valid(periodic_exec_valid),
        .exec_slot(periodic_exec_slot),
        .scan_slot()
    );
    dls_scanner u_async_scan (
        .clock(clock),
        .rst(rst),
        .scan_en(scan_en),
        .valid_map(async_valid),
        .skip_map(async_skip_map_reg),
        .last_map(async_last_map_reg),
        .exec_ready(async_exec_ready),
        .exec_valid(async_exec_valid),
        .exec_slot(async_exec_slot),
        .scan_slot()
    );
endmodule // dls_top
